//--- hdl/interval_timer.sv
// one-shot interval timer giving a single-cycle expiry pulse
`timescale 1ns/1ps
module interval_timer (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // control
  input  wire logic                        start,
  input  wire logic [seq_pkg::TIMER_W-1:0] load,
  // status
  output logic                             busy,
  output logic                             expire
);

  logic [seq_pkg::TIMER_W-1:0] count;

  // expire comes load cycles after the start edge; a new start restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count  <= '0;
      busy   <= 1'b0;
      expire <= 1'b0;
    end else if (start) begin
      count  <= load;
      busy   <= 1'b1;
      expire <= 1'b0;
    end else if (busy && count <= 20'h0_0001) begin
      busy   <= 1'b0;
      expire <= 1'b1;
    end else begin
      count  <= busy ? count - 20'h0_0001 : count;
      expire <= 1'b0;
    end
  end

endmodule // interval_timer

//--- hdl/regulator_startup_sequencer.sv
// slot-based regulator power-up and power-down sequencer with AXI4-Lite registers
`timescale 1ns/1ps

// Overview of operation
// - power-up slots follow each other every 0.5 ms with slot speed select 0 and every 2.0 ms with it 1.
// - the processor reset is released 2.0 ms after the last sequenced regulator was enabled.
// - while powering down, 2.0 ms pass between switching off one slot and the next.
// - after a cold start the backup supply comes on 0.6 ms after valid input, before any regulator.
// - the bus target address is 0x08 in every configuration and reads back from a register.
// - a regulator's 3-bit up slot, 1 to 7, picks when it is enabled as the slot timer advances in order; 0 leaves it off.
// - the processor reset stays asserted from power-on reset until the power-up sequence has ended.
// - power-down switches regulators off one slot at a time in descending order of their down slots.
// - if every down slot is zero, all regulators are switched off at once.
// - power-up ends as soon as the last assigned regulator is enabled, not after a fixed slot count.
module regulator_startup_sequencer #(
  parameter int SLOT_FAST_CYC  = seq_pkg::SLOT_FAST_CYC,
  parameter int SLOT_SLOW_CYC  = seq_pkg::SLOT_SLOW_CYC,
  parameter int RESET_DLY_CYC  = seq_pkg::RESET_DLY_CYC,
  parameter int DOWN_GAP_CYC   = seq_pkg::DOWN_GAP_CYC,
  parameter int BACKUP_DLY_CYC = seq_pkg::BACKUP_DLY_CYC
) (
  // clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // pins from outside
  input  wire logic                       input_valid,
  input  wire logic                       power_on_request,
  // supply and reset outputs
  output seq_pkg::supply_out_s            supply_out,
  // axi4-lite write address
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [seq_pkg::ADDR_W-1:0] awaddr,
  // axi4-lite write data
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  // axi4-lite write response
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic [1:0]                      bresp,
  // axi4-lite read address
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [seq_pkg::ADDR_W-1:0] araddr,
  // axi4-lite read data
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  seq_pkg::seq_state_e         state;
  seq_pkg::seq_state_e         next_state;
  logic [2:0]                  cur_slot;
  logic [2:0]                  next_slot;
  logic [6:0]                  reg_en;
  logic [6:0]                  next_en;
  logic                        backup_on;
  logic                        next_backup;
  logic                        released;
  logic                        next_released;
  logic                        tmr_start;
  logic [seq_pkg::TIMER_W-1:0] tmr_load;
  logic                        tmr_expire;
  logic                        speed_sel;
  logic [31:0]                 up_cfg;
  logic [31:0]                 dn_cfg;
  logic [1:0]                  sync1;
  logic [1:0]                  sync2;
  logic [1:0]                  sync3;
  logic [1:0]                  pin_in;
  logic [1:0]                  pin_q;
  logic                        input_ok;
  logic                        power_req;
  logic [6:0]                  up_hit;
  logic [6:0]                  dn_hit;
  logic [7:0]                  used_up;
  logic [7:0]                  used_dn;
  logic [3:0]                  first_up;
  logic [3:0]                  up_after;
  logic [3:0]                  top_dn;
  logic [3:0]                  dn_below;
  logic [seq_pkg::TIMER_W-1:0] slot_len;
  logic [seq_pkg::TIMER_W-1:0] reset_len;
  logic [seq_pkg::TIMER_W-1:0] gap_len;
  logic [seq_pkg::TIMER_W-1:0] backup_len;
  logic                        aw_full;
  logic                        w_full;
  logic [seq_pkg::ADDR_W-1:0]  aw_addr;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;
  logic                        do_write;
  logic                        wr_ctrl;
  logic                        wr_up;
  logic                        wr_dn;
  logic                        wr_known;
  logic                        up_locked;
  logic                        rd_known;
  logic [31:0]                 rd_word;
  logic [31:0]                 status_word;

  ////////////////////////////////////////////////////////////////////////////
  // helpers over the seven slot fields
  function automatic logic [7:0] used_slots(input logic [31:0] cfg);
    logic [7:0] u;
    u = '0;
    for (int r = 0; r < seq_pkg::NUM_REG; r++) begin
      u[cfg[seq_pkg::FIELD_W*r +: seq_pkg::SLOT_W]] = 1'b1;
    end
    return u;
  endfunction

  // lowest used slot above cur, found flag in the top bit
  function automatic logic [3:0] find_above(input logic [7:0] used, input int cur);
    logic [3:0] res;
    res = '0;
    for (int s = seq_pkg::NUM_SLOT - 1; s >= 0; s--) begin
      if (s > cur && used[s]) begin
        res = {1'b1, 3'(s)};
      end
    end
    return res;
  endfunction

  // highest used slot below cur, found flag in the top bit
  function automatic logic [3:0] find_below(input logic [7:0] used, input int cur);
    logic [3:0] res;
    res = '0;
    for (int s = 0; s < seq_pkg::NUM_SLOT; s++) begin
      if (s < cur && used[s]) begin
        res = {1'b1, 3'(s)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: value moves only when stages two and three agree
  assign pin_in = {power_on_request, input_valid};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_q[p] <= 1'b0;
        end else if (sync2[p] == sync3[p]) begin
          pin_q[p] <= sync3[p];
        end
      end
    end
  endgenerate

  assign input_ok  = pin_q[0];
  assign power_req = pin_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // slot decoding per regulator; down hits look at the next lower group, the top one went on entry
  generate
    for (genvar r = 0; r < seq_pkg::NUM_REG; r++) begin : g_hit
      assign up_hit[r] = (up_cfg[seq_pkg::FIELD_W*r +: seq_pkg::SLOT_W] == cur_slot);
      assign dn_hit[r] = (dn_cfg[seq_pkg::FIELD_W*r +: seq_pkg::SLOT_W] == dn_below[2:0]);
    end
  endgenerate

  // up slot 0 means not sequenced; down slot 0 is the last group off
  assign used_up  = used_slots(up_cfg) & 8'hfe;
  assign used_dn  = used_slots(dn_cfg);
  assign first_up = find_above(used_up, -1);
  assign up_after = find_above(used_up, int'(cur_slot));
  assign top_dn   = find_below(used_dn, seq_pkg::NUM_SLOT);
  assign dn_below = find_below(used_dn, int'(cur_slot));

  // interval lengths
  assign slot_len   = speed_sel ? seq_pkg::TIMER_W'(SLOT_SLOW_CYC)
                                : seq_pkg::TIMER_W'(SLOT_FAST_CYC);
  assign reset_len  = seq_pkg::TIMER_W'(RESET_DLY_CYC);
  assign gap_len    = seq_pkg::TIMER_W'(DOWN_GAP_CYC);
  assign backup_len = seq_pkg::TIMER_W'(BACKUP_DLY_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next-state logic
  always_comb begin
    next_state    = state;
    next_slot     = cur_slot;
    next_en       = reg_en;
    next_backup   = backup_on;
    next_released = released;
    tmr_start     = 1'b0;
    tmr_load      = slot_len;
    case (state)
      seq_pkg::ST_COLD: begin
        if (input_ok) begin
          tmr_start  = 1'b1;
          tmr_load   = backup_len;
          next_state = seq_pkg::ST_BACKUP_WAIT;
        end
      end
      seq_pkg::ST_BACKUP_WAIT: begin
        if (tmr_expire) begin
          next_backup = 1'b1;
          next_state  = seq_pkg::ST_OFF;
        end
      end
      seq_pkg::ST_OFF: begin
        if (power_req && first_up[3]) begin
          next_slot  = first_up[2:0];
          tmr_start  = 1'b1;
          next_state = seq_pkg::ST_UP;
        end else if (power_req) begin
          tmr_start  = 1'b1;
          tmr_load   = reset_len;
          next_state = seq_pkg::ST_RESET_WAIT;
        end
      end
      seq_pkg::ST_UP: begin
        if (tmr_expire) begin
          next_en = reg_en | up_hit;
          if (up_after[3]) begin
            next_slot = up_after[2:0];
            tmr_start = 1'b1;
          end else begin
            tmr_start  = 1'b1;
            tmr_load   = reset_len;
            next_state = seq_pkg::ST_RESET_WAIT;
          end
        end
      end
      seq_pkg::ST_RESET_WAIT: begin
        if (tmr_expire) begin
          next_released = 1'b1;
          next_state    = seq_pkg::ST_RUN;
        end
      end
      seq_pkg::ST_RUN: begin
        if (!power_req) begin
          next_released = 1'b0;
          next_slot     = top_dn[2:0];
          tmr_start     = 1'b1;
          tmr_load      = gap_len;
          next_state    = seq_pkg::ST_DOWN;
        end
      end
      seq_pkg::ST_DOWN: begin
        if (tmr_expire || cur_slot == top_dn[2:0] && !released && dn_below == 4'h0 && used_dn == 8'h01) begin
          next_en = reg_en & ~dn_hit;
          if (dn_below[3]) begin
            next_slot = dn_below[2:0];
            tmr_start = 1'b1;
            tmr_load  = gap_len;
          end else begin
            next_en    = '0;
            next_state = seq_pkg::ST_OFF;
          end
        end
      end
      default: begin
        next_state = seq_pkg::ST_COLD;
      end
    endcase
  end

  // sequencer state; first down group goes off on entry to the down state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= seq_pkg::ST_COLD;
      cur_slot  <= '0;
      reg_en    <= '0;
      backup_on <= 1'b0;
      released  <= 1'b0;
    end else begin
      state     <= next_state;
      cur_slot  <= next_slot;
      reg_en    <= (state == seq_pkg::ST_RUN && !power_req) ? reg_en & ~dn_hit_top() : next_en;
      backup_on <= next_backup;
      released  <= next_released;
    end
  end

  // regulators in the highest used down slot, switched off with no wait
  function automatic logic [6:0] dn_hit_top();
    logic [6:0] h;
    h = '0;
    for (int r = 0; r < seq_pkg::NUM_REG; r++) begin
      h[r] = (dn_cfg[seq_pkg::FIELD_W*r +: seq_pkg::SLOT_W] == top_dn[2:0]);
    end
    return (used_dn == 8'h01) ? 7'h7f : h;
  endfunction

  // outputs straight from the state flops
  assign supply_out.regulator_en          = reg_en;
  assign supply_out.backup_supply         = backup_on;
  assign supply_out.processor_reset_out_n = released;

  // interval timer shared by every wait
  interval_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start),
    .load    (tmr_load),
    .busy    (),
    .expire  (tmr_expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite decode; up slots are frozen from power-up until power-down returns to off
  assign do_write  = aw_full && w_full && !bvalid;
  assign up_locked = !(state == seq_pkg::ST_COLD || state == seq_pkg::ST_BACKUP_WAIT || state == seq_pkg::ST_OFF);
  assign wr_ctrl   = do_write && aw_addr == seq_pkg::OFF_CTRL;
  assign wr_up     = do_write && aw_addr == seq_pkg::OFF_UP_SLOT && !up_locked;
  assign wr_dn     = do_write && aw_addr == seq_pkg::OFF_DN_SLOT;
  assign wr_known  = aw_addr == seq_pkg::OFF_CTRL || aw_addr == seq_pkg::OFF_UP_SLOT
                  || aw_addr == seq_pkg::OFF_DN_SLOT || aw_addr == seq_pkg::OFF_STATUS
                  || aw_addr == seq_pkg::OFF_TARGET;
  assign rd_known  = wr_known_rd(araddr);
  assign status_word = {4'h0, 1'b0, state, 5'h00, cur_slot, 6'h00, released, backup_on, 1'b0, reg_en};
  assign rd_word   = (araddr == seq_pkg::OFF_CTRL)    ? {31'h0000_0000, speed_sel} :
                     (araddr == seq_pkg::OFF_UP_SLOT) ? up_cfg :
                     (araddr == seq_pkg::OFF_DN_SLOT) ? dn_cfg :
                     (araddr == seq_pkg::OFF_STATUS)  ? status_word :
                     (araddr == seq_pkg::OFF_TARGET)  ? {25'h000_0000, seq_pkg::TARGET_ADDR} :
                     32'h0000_0000;

  function automatic logic wr_known_rd(input logic [seq_pkg::ADDR_W-1:0] a);
    return a == seq_pkg::OFF_CTRL || a == seq_pkg::OFF_UP_SLOT || a == seq_pkg::OFF_DN_SLOT
        || a == seq_pkg::OFF_STATUS || a == seq_pkg::OFF_TARGET;
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction

  // write address and data channels, taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= '0;
      wready  <= 1'b0;
      w_full  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      awready <= !(awvalid && awready) && !aw_full && !bvalid;
      aw_full <= (awvalid && awready) || (aw_full && !(bvalid && bready));
      aw_addr <= (awvalid && awready) ? awaddr : aw_addr;
      wready  <= !(wvalid && wready) && !w_full && !bvalid;
      w_full  <= (wvalid && wready) || (w_full && !(bvalid && bready));
      w_data  <= (wvalid && wready) ? wdata : w_data;
      w_strb  <= (wvalid && wready) ? wstrb : w_strb;
    end
  end

  // register writes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_sel <= seq_pkg::CTRL_RST;
      up_cfg    <= seq_pkg::UP_SLOT_RST;
      dn_cfg    <= seq_pkg::DN_SLOT_RST;
      bvalid    <= 1'b0;
      bresp     <= seq_pkg::RESP_OKAY;
    end else begin
      speed_sel <= (wr_ctrl && w_strb[0]) ? w_data[seq_pkg::CTRL_SPEED] : speed_sel;
      up_cfg    <= wr_up ? merge(up_cfg, w_data, w_strb) & 32'h0777_7777 : up_cfg;
      dn_cfg    <= wr_dn ? merge(dn_cfg, w_data, w_strb) & 32'h0777_7777 : dn_cfg;
      bvalid    <= do_write || (bvalid && !bready);
      bresp     <= do_write ? (wr_known ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR) : bresp;
    end
  end

  // read channel, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= seq_pkg::RESP_OKAY;
    end else begin
      arready <= !(arvalid && arready) && !rvalid;
      rvalid  <= (arvalid && arready) || (rvalid && !rready);
      rdata   <= (arvalid && arready) ? rd_word : rdata;
      rresp   <= (arvalid && arready) ? (rd_known ? seq_pkg::RESP_OKAY : seq_pkg::RESP_SLVERR) : rresp;
    end
  end

endmodule // regulator_startup_sequencer

//--- hdl/seq_pkg.sv
// shared constants, types and register map of the regulator start-up sequencer
package seq_pkg;

  // clock and timing
  localparam int  CLK_KHZ        = 250000;
  localparam real SLOT_FAST_MS   = 0.5;
  localparam real SLOT_SLOW_MS   = 2.0;
  localparam real RESET_DELAY_MS = 2.0;
  localparam real DOWN_GAP_MS    = 2.0;
  localparam real BACKUP_DLY_MS  = 0.6;
  localparam int  SLOT_FAST_CYC  = int'(SLOT_FAST_MS * CLK_KHZ);
  localparam int  SLOT_SLOW_CYC  = int'(SLOT_SLOW_MS * CLK_KHZ);
  localparam int  RESET_DLY_CYC  = int'(RESET_DELAY_MS * CLK_KHZ);
  localparam int  DOWN_GAP_CYC   = int'(DOWN_GAP_MS * CLK_KHZ);
  localparam int  BACKUP_DLY_CYC = int'(BACKUP_DLY_MS * CLK_KHZ);
  localparam int  TIMER_W        = 20;

  // regulators and slot fields
  localparam int NUM_REG  = 7;
  localparam int SLOT_W   = 3;
  localparam int FIELD_W  = 4;
  localparam int NUM_SLOT = 8;

  // register map, byte addresses
  localparam int          ADDR_W       = 5;
  localparam logic [4:0]  OFF_CTRL     = 5'h00;
  localparam logic [4:0]  OFF_UP_SLOT  = 5'h04;
  localparam logic [4:0]  OFF_DN_SLOT  = 5'h08;
  localparam logic [4:0]  OFF_STATUS   = 5'h0c;
  localparam logic [4:0]  OFF_TARGET   = 5'h10;
  localparam int          CTRL_SPEED   = 0;
  localparam int          ST_BACKUP    = 8;
  localparam int          ST_RELEASED  = 9;
  localparam int          ST_SLOT_LSB  = 16;
  localparam int          ST_STATE_LSB = 24;
  localparam logic        CTRL_RST     = 1'b0;
  // fields: buck1 buck2 buck3 linreg1 linreg2 linreg3 memref, low nibble first
  localparam logic [31:0] UP_SLOT_RST  = 32'h0312_1234;
  localparam logic [31:0] DN_SLOT_RST  = UP_SLOT_RST;
  localparam logic [6:0]  TARGET_ADDR  = 7'h08;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // sequencer states
  typedef enum logic [2:0] {
    ST_COLD, ST_BACKUP_WAIT, ST_OFF, ST_UP, ST_RESET_WAIT, ST_RUN, ST_DOWN
  } seq_state_e;

  // supply outputs travelling together
  typedef struct packed {
    logic [6:0] regulator_en;
    logic       backup_supply;
    logic       processor_reset_out_n;
  } supply_out_s;

endpackage

//--- tb/proc_model.sv
// application processor model: asks for power, watches its reset
`timescale 1ns/1ps
module proc_model (
  // bench command
  input  wire logic want_on,
  // pins toward the sequencer
  output logic      power_on_request,
  input  wire logic processor_reset_out_n,
  // status back to the bench
  output logic      running
);
  // the request is a plain level; the device syncs it, so no edge shaping
  assign power_on_request = want_on;
  assign running          = processor_reset_out_n;
endmodule // proc_model

//--- tb/seq_chk_chk.sv
// concurrent checks on supply outputs and the target register
`timescale 1ns/1ps
module seq_chk #(
  parameter int SLOT_FAST_CYC = 5,
  parameter int SLOT_SLOW_CYC = 20,
  parameter int RESET_DLY_CYC = 20,
  parameter int DOWN_GAP_CYC  = 20
) (
  // clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // outputs watched
  input wire seq_pkg::supply_out_s       supply_out,
  // read channel
  input wire logic                       arvalid,
  input wire logic                       arready,
  input wire logic [seq_pkg::ADDR_W-1:0] araddr,
  input wire logic [31:0]                rdata
);
  logic [6:0] prev_en;
  logic       prev_rn;
  int         cnt;
  wire  [6:0] en   = supply_out.regulator_en;
  wire        rn   = supply_out.processor_reset_out_n;
  wire        gain = |(en & ~prev_en);
  wire        lose = |(~en & prev_en);
  // cycles since enables last moved; spacing checks read it at the next move
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_en <= '0;
      prev_rn <= 1'b0;
      cnt     <= 0;
    end else begin
      prev_en <= en;
      prev_rn <= rn;
      cnt     <= (en != prev_en) ? 0 : cnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // window of two cycles either side, the timer hand-off costs an edge or so
  sequence s_settled(int n);
    cnt >= n - 2 && cnt <= n + 2;
  endsequence
  property p_backup_first; en != 0 |-> supply_out.backup_supply; endproperty
  property p_up_gap; gain && prev_en != 0 |-> s_settled(SLOT_FAST_CYC) or s_settled(SLOT_SLOW_CYC); endproperty
  property p_rel_gap; rn && !prev_rn && en != 0 |-> s_settled(RESET_DLY_CYC); endproperty
  property p_down_gap; lose && !prev_rn |-> s_settled(DOWN_GAP_CYC); endproperty
  property p_up_in_rst; gain |-> !rn; endproperty
  property p_down_in_rst; lose |-> !rn; endproperty
  property p_rst_with_down; $fell(rn) |-> lose; endproperty
  property p_target; arvalid && arready && araddr == 5'h10 |=> rdata[6:0] == 7'h08; endproperty
  a_backup_first: assert property (p_backup_first) else $error("regulator on without backup");
  a_up_gap: assert property (p_up_gap) else $error("slot spacing off");
  a_rel_gap: assert property (p_rel_gap) else $error("reset release delay off");
  a_down_gap: assert property (p_down_gap) else $error("down spacing off");
  a_up_in_rst: assert property (p_up_in_rst) else $error("enable after reset release");
  a_down_in_rst: assert property (p_down_in_rst) else $error("switch-off with reset high");
  a_rst_with_down: assert property (p_rst_with_down) else $error("reset fell without down step");
  a_target: assert property (p_target) else $error("target address wrong");
endmodule // seq_chk

bind regulator_startup_sequencer seq_chk #(.SLOT_FAST_CYC(SLOT_FAST_CYC), .SLOT_SLOW_CYC(SLOT_SLOW_CYC),
  .RESET_DLY_CYC(RESET_DLY_CYC), .DOWN_GAP_CYC(DOWN_GAP_CYC)) seq_chk_i (.aclk(aclk), .aresetn(aresetn),
  .supply_out(supply_out), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rdata(rdata));

//--- tb/tb.sv
// self-checking bench for the regulator start-up sequencer
`timescale 1ns/1ps
module tb;
  localparam int FAST = 5;
  localparam int SLOW = 20;
  localparam int RDLY = 20;
  localparam int DGAP = 20;
  localparam int BDLY = 6;
  logic                 aclk = 0, aresetn = 0, input_valid = 0, want_on = 0;
  logic                 awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic                 awready, wready, bvalid, arready, rvalid, power_on_request, running;
  logic [4:0]           awaddr = 0, araddr = 0;
  logic [31:0]          wdata = 0, rdata;
  logic [1:0]           bresp, rresp;
  seq_pkg::supply_out_s supply_out;
  int                   bad_count = 0, num_checks = 0, cyc = 0;

  regulator_startup_sequencer #(.SLOT_FAST_CYC(FAST), .SLOT_SLOW_CYC(SLOW), .RESET_DLY_CYC(RDLY),
    .DOWN_GAP_CYC(DGAP), .BACKUP_DLY_CYC(BDLY)) regulator_startup_sequencer_i (.aclk(aclk),
    .aresetn(aresetn), .input_valid(input_valid), .power_on_request(power_on_request),
    .supply_out(supply_out), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp));
  proc_model proc_model_i (.want_on(want_on), .power_on_request(power_on_request),
    .processor_reset_out_n(supply_out.processor_reset_out_n), .running(running));

  always #2 aclk = ~aclk;
  // hang guard, well above three rounds of the slowest spacing
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 0;
    w_done = 0;
    do begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // edges until the supply outputs move, read before this edge lands
  task automatic wait_chg(output int d);
    seq_pkg::supply_out_s last;
    last = supply_out;
    d = 0;
    do begin
      @(posedge aclk);
      d++;
    end while (supply_out === last);
  endtask
  task automatic step(input logic [6:0] cur, input logic rn, input int gap, input bit first, input string w);
    int d;
    wait_chg(d);
    chk(32'({cur, 1'b1, rn}), 32'(supply_out), w);
    if (!first) chk(32'(d >= gap - 1 && d <= gap + 3), 1, w);
  endtask
  // one cold start, power-up, release and power-down against the slot model
  task automatic round(input logic spd, input bit rnd, input bit zero_dn);
    logic [31:0] upw, dnw, rd;
    logic [1:0]  rs;
    logic [6:0]  cur, m;
    int          d, s, r;
    bit          first;
    aresetn <= 1'b0;
    input_valid <= 1'b0;
    want_on <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    upw = 32'h0312_1234;
    axi_rd(seq_pkg::OFF_UP_SLOT, rd, rs);
    chk(rd, upw, "up slot reset");
    if (rnd) for (r = 0; r < 7; r++) upw[4*r+:3] = 3'(1 + $urandom % 7);
    dnw = upw;
    if (rnd) for (r = 0; r < 7; r++) dnw[4*r+:3] = 3'($urandom % 8);
    if (zero_dn) dnw = 32'h0000_0000;
    axi_wr(seq_pkg::OFF_CTRL, {31'h0, spd}, rs);
    axi_wr(seq_pkg::OFF_UP_SLOT, upw, rs);
    axi_wr(seq_pkg::OFF_DN_SLOT, dnw, rs);
    chk(32'(rs), 32'(seq_pkg::RESP_OKAY), "write resp");
    @(posedge aclk);
    input_valid <= 1'b1;
    wait_chg(d);
    chk(32'(supply_out), 32'h0000_0002, "backup");
    chk(32'(d >= BDLY && d <= BDLY + 8), 1, "backup delay");
    want_on <= 1'b1;
    cur = '0;
    first = 1;
    for (s = 1; s < 8; s++) begin
      for (r = 0; r < 7; r++) m[r] = (upw[4*r+:3] == s);
      if (m != 0) begin
        cur |= m;
        step(cur, 1'b0, spd ? SLOW : FAST, first, "up step");
        first = 0;
      end
    end
    step(cur, 1'b1, RDLY, 0, "release");
    chk(32'(running), 1, "processor running");
    axi_wr(seq_pkg::OFF_UP_SLOT, ~upw, rs);
    axi_rd(seq_pkg::OFF_UP_SLOT, rd, rs);
    chk(rd, upw, "up slots locked");
    want_on <= 1'b0;
    first = 1;
    for (s = 7; s >= 0; s--) begin
      for (r = 0; r < 7; r++) m[r] = cur[r] && (dnw[4*r+:3] == s);
      if (m != 0) begin
        cur &= ~m;
        step(cur, 1'b0, DGAP, first, "down step");
        first = 0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic [1:0]  rs;
    void'($urandom(39));
    round(1'b0, 1'b0, 1'b0);
    axi_rd(seq_pkg::OFF_TARGET, rd, rs);
    chk(rd, 32'h0000_0008, "target");
    axi_rd(5'h14, rd, rs);
    chk({rd[29:0], rs}, 32'h0000_0002, "unmapped");
    round(1'b1, 1'b1, 1'b0);
    round(1'b0, 1'b1, 1'b1);
    final_report();
  end
endmodule // tb
